// ===== verilog/reset_strap_config_latch.sv
`timescale 1ns/1ns
// What this block does
// R01: board holds every strap level steadily until reset is released.
// R02: lane strap low puts narrow memory data on the lowest byte lane.
// R03: lane strap high: low lane little-endian, top lane big-endian.
// R04: byte order strap low means big-endian, high means little-endian.
// R05: boot code 00 boots through the host port or emulation.
// R06: boot codes 01, 10, 11 boot from rom, widths 8, 16, 32.
// R07: clock strap high selects square-wave input; low is reserved.
// R08: software changes configuration through a register at a fixed address.
// R09: board may only drive host data pins 12, 8, 4, 3 at reset.
// R10: configuration bit 4 picks memory clock: 0 internal, 1 external pin.
// R11: straps are taken at reset release and held until next reset.
module reset_strap_config_latch
  import strap_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] host_data_pins,
  input  wire logic        clock_source_strap,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             big_endian,
  output logic [1:0]       narrow_lane_select,
  output logic             boot_from_host_port,
  output logic [5:0]       rom_width,
  output logic             clock_source_square_wave,
  output logic             clock_source_reserved,
  output logic             memory_clock_external,
  output logic             config_valid
);
  import strap_cfg_pkg::*;

  logic [16:0] cap;
  logic        cap_valid;
  logic [31:0] device_configuration;

  // straps are sampled at reset release; R01 and R09 fall on the board
  strap_sampler #(
    .WIDTH(17)
  ) u_sampler (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pins    ({clock_source_strap, host_data_pins}),
    .captured(cap),
    .valid   (cap_valid)
  ); // R11

  // decode of the captured straps
  wire       narrow_lane_strap = cap[NARROW_LANE_POS];
  wire       byte_order_strap  = cap[BYTE_ORDER_POS];
  wire [1:0] boot_code         = cap[BOOT_SRC_HI:BOOT_SRC_LO];
  wire       clk_strap         = cap[16];
  wire       is_big            = ~byte_order_strap; // R04
  wire [1:0] next_lane         = (narrow_lane_strap && is_big) ?
                                 LANE_TOP : LANE_LOW; // R02 R03
  wire       next_host_boot    = (boot_code == BOOT_HOST); // R05
  wire [5:0] next_width        = (boot_code == BOOT_ROM8)  ? WIDTH_8  :
                                 (boot_code == BOOT_ROM16) ? WIDTH_16 :
                                 (boot_code == BOOT_ROM32) ? WIDTH_32 :
                                 6'h00; // R06

  // apb decode
  wire        access    = psel & penable;
  wire        hit_cfg   = (paddr == DEVICE_CONFIGURATION_ADDR);
  wire        hit_stat  = (paddr == STRAP_STATUS_ADDR);
  wire        mapped    = hit_cfg | hit_stat;
  wire        wr_cfg    = access & pwrite & hit_cfg & pstrb[0]; // R08
  wire        bad       = access & (~mapped | (pwrite & hit_stat));
  wire [31:0] status_word =
    (32'h1 << ST_BOOT_HOST) & {32{next_host_boot}} |
    ({26'h0, next_width} << ST_ROM_WIDTH_LO) |
    ({31'h0, clk_strap} << ST_CLOCK_SRC) |
    ({31'h0, narrow_lane_strap} << ST_NARROW_LANE) |
    ({31'h0, byte_order_strap} << ST_BYTE_ORDER) |
    ({30'h0, boot_code} << ST_BOOT_LO);
  wire [31:0] next_prdata =
    (access & ~pwrite & hit_cfg)  ? device_configuration :
    (access & ~pwrite & hit_stat) ? status_word : 32'h00000000;
  // only the clock source bit is writable; reserved bits stay zero
  wire [31:0] next_cfg = wr_cfg ?
    (pwdata & (32'h1 << MEMORY_CLOCK_SOURCE_BIT)) : device_configuration;

  // register file and bus answer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      device_configuration <= DEVICE_CONFIGURATION_RST;
      prdata               <= 32'h00000000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      device_configuration <= next_cfg; // R08 R10
      prdata               <= next_prdata;
      pready               <= access & ~pready;
      pslverr              <= bad & ~pready;
    end
  end

  // configuration outputs, all registered
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      big_endian               <= 1'b0;
      narrow_lane_select       <= LANE_LOW;
      boot_from_host_port      <= 1'b0;
      rom_width                <= 6'h00;
      clock_source_square_wave <= 1'b0;
      clock_source_reserved    <= 1'b0;
      memory_clock_external    <= 1'b0;
      config_valid             <= 1'b0;
    end else begin
      big_endian               <= is_big; // R04
      narrow_lane_select       <= next_lane; // R02 R03
      boot_from_host_port      <= next_host_boot; // R05
      rom_width                <= next_width; // R06
      clock_source_square_wave <= clk_strap; // R07
      clock_source_reserved    <= cap_valid & ~clk_strap; // R07
      memory_clock_external    <=
        device_configuration[MEMORY_CLOCK_SOURCE_BIT]; // R10
      config_valid             <= cap_valid;
    end
  end

  // lane placement, checked one edge behind the captured straps
  lane_place_a: assert property ( // R02
    @(posedge sys_clk) disable iff (sys_rst)
    config_valid & ~narrow_lane_select[0] |->
    !$past(narrow_lane_strap) || $past(byte_order_strap))
    else $error("narrow lane wrong");
  lane_low_a: assert property ( // R02
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && !$past(narrow_lane_strap) |->
    narrow_lane_select == LANE_LOW)
    else $error("low lane missed");
  lane_top_a: assert property ( // R03
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && $past(narrow_lane_strap) && !$past(byte_order_strap)
    |-> narrow_lane_select == LANE_TOP)
    else $error("top lane missed");
  lane_little_a: assert property ( // R03
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && $past(byte_order_strap) |->
    narrow_lane_select == LANE_LOW)
    else $error("little lane wrong");

  // byte order is the inverse of its strap
  endian_mode_a: assert property ( // R04
    @(posedge sys_clk) disable iff (sys_rst)
    config_valid |-> big_endian == !$past(byte_order_strap))
    else $error("endian wrong");

  // boot source and rom width
  host_boot_a: assert property ( // R05
    @(posedge sys_clk) disable iff (sys_rst)
    config_valid |-> boot_from_host_port == (rom_width == 6'h00))
    else $error("boot mode wrong");
  host_code_a: assert property ( // R05
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && $past(boot_code) == BOOT_HOST |->
    boot_from_host_port)
    else $error("host boot missed");
  rom8_a: assert property ( // R06
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && $past(boot_code) == BOOT_ROM8 |->
    rom_width == WIDTH_8)
    else $error("rom width 8 wrong");
  rom_width_a: assert property ( // R06
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && $past(boot_code) == BOOT_ROM16 |->
    rom_width == WIDTH_16)
    else $error("rom width wrong");
  rom32_a: assert property ( // R06
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) && $past(boot_code) == BOOT_ROM32 |->
    rom_width == WIDTH_32)
    else $error("rom width 32 wrong");

  // clock source strap; its low level is reserved
  clk_src_a: assert property ( // R07
    @(posedge sys_clk) disable iff (sys_rst)
    config_valid |-> clock_source_square_wave != clock_source_reserved)
    else $error("clock source wrong");
  clk_square_a: assert property ( // R07
    @(posedge sys_clk) disable iff (sys_rst)
    $past(cap_valid) |-> clock_source_square_wave == $past(clk_strap))
    else $error("square wave source wrong");
  rsv_valid_a: assert property ( // R07
    @(posedge sys_clk) disable iff (sys_rst)
    clock_source_reserved |-> config_valid)
    else $error("reserved flag early");

  // configuration register writes and the memory clock bit
  cfg_write_a: assert property ( // R08 R10
    @(posedge sys_clk) disable iff (sys_rst)
    wr_cfg |-> ##2 memory_clock_external == $past(pwdata[4], 2))
    else $error("clock bit write lost");
  write_bit_a: assert property ( // R10
    @(posedge sys_clk) disable iff (sys_rst)
    wr_cfg |=> device_configuration[MEMORY_CLOCK_SOURCE_BIT] ==
    $past(pwdata[MEMORY_CLOCK_SOURCE_BIT]))
    else $error("clock bit not stored");
  cfg_reserved_a: assert property ( // R10
    @(posedge sys_clk) disable iff (sys_rst)
    (device_configuration & ~(32'h1 << MEMORY_CLOCK_SOURCE_BIT)) == 32'h0)
    else $error("reserved config bit set");
  strobe_skip_a: assert property ( // R08
    @(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && hit_cfg && !pstrb[0] |=>
    $stable(device_configuration))
    else $error("unstrobed write landed");
  ext_follow_a: assert property ( // R10
    @(posedge sys_clk) disable iff (sys_rst)
    memory_clock_external ==
    $past(device_configuration[MEMORY_CLOCK_SOURCE_BIT]))
    else $error("memory clock select stale");

  // bus answer: one wait state, ready for one cycle
  read_cfg_a: assert property ( // R08
    @(posedge sys_clk) disable iff (sys_rst)
    access && !pwrite && hit_cfg && !pready |=>
    pready && prdata == $past(device_configuration))
    else $error("config read wrong");
  status_ro_a: assert property ( // R08
    @(posedge sys_clk) disable iff (sys_rst)
    access && pwrite && hit_stat && !pready |=> pready && pslverr)
    else $error("status write not refused");
  pready_once_a: assert property ( // R08
    @(posedge sys_clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property ( // R08
    @(posedge sys_clk) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("error without ready");

  // captured configuration stays put until the next reset
  cfg_hold_a: assert property ( // R11
    @(posedge sys_clk) disable iff (sys_rst)
    $past(config_valid) |-> $stable(big_endian) && $stable(rom_width))
    else $error("config moved");
  valid_hold_a: assert property ( // R11
    @(posedge sys_clk) disable iff (sys_rst)
    config_valid |=> config_valid)
    else $error("config valid dropped");
endmodule

// ===== verilog/strap_cfg_pkg.sv
package strap_cfg_pkg;
  // register map
  localparam logic [31:0] DEVICE_CONFIGURATION_ADDR = 32'h019c0200;
  localparam logic [31:0] DEVICE_CONFIGURATION_RST  = 32'h00000000;
  localparam logic [31:0] STRAP_STATUS_ADDR         = 32'h019c0204;
  localparam int          MEMORY_CLOCK_SOURCE_BIT   = 4;
  // strap positions on the host data pins
  localparam int          NARROW_LANE_POS           = 12;
  localparam int          BYTE_ORDER_POS            = 8;
  localparam int          BOOT_SRC_HI               = 4;
  localparam int          BOOT_SRC_LO               = 3;
  // status register field positions
  localparam int          ST_BOOT_LO                = 0;
  localparam int          ST_BYTE_ORDER             = 2;
  localparam int          ST_NARROW_LANE            = 3;
  localparam int          ST_CLOCK_SRC              = 4;
  localparam int          ST_BOOT_HOST              = 5;
  localparam int          ST_ROM_WIDTH_LO           = 8;
  // boot source codes
  localparam logic [1:0]  BOOT_HOST                 = 2'h0;
  localparam logic [1:0]  BOOT_ROM8                 = 2'h1;
  localparam logic [1:0]  BOOT_ROM16                = 2'h2;
  localparam logic [1:0]  BOOT_ROM32                = 2'h3;
  // byte lane selects
  localparam logic [1:0]  LANE_LOW                  = 2'h0;
  localparam logic [1:0]  LANE_TOP                  = 2'h3;
  // rom widths in bits
  localparam logic [5:0]  WIDTH_8                   = 6'h08;
  localparam logic [5:0]  WIDTH_16                  = 6'h10;
  localparam logic [5:0]  WIDTH_32                  = 6'h20;
endpackage

// ===== verilog/strap_sampler.sv
`timescale 1ns/1ns
module strap_sampler #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] captured,
  output logic                  valid
);
  logic             armed;
  logic [WIDTH-1:0] next_captured;

  // take the pins once, at the first edge after reset release
  assign next_captured = armed ? captured : pins;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed    <= 1'b0;
      captured <= '0;
      valid    <= 1'b0;
    end else begin
      armed    <= 1'b1;
      captured <= next_captured; // R11
      valid    <= 1'b1;
    end
  end

  // later pin activity never reaches the captured value
  hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // R11
    armed |=> $stable(captured)) else $error("straps changed");
endmodule

// ===== tb/board_straps.sv
`timescale 1ns/1ns
module board_straps (
  input  wire logic       wiggle,
  input  wire logic [3:0] strap_set,
  output logic [15:0]     host_data_pins,
  output logic            clock_source_strap
);
  logic [15:0] level;
  // straps on 12, 8, 4:3; other pins sit at their pull level
  assign level = {3'h0, strap_set[3], 3'h0, strap_set[2], 3'h0,
                  strap_set[1:0], 3'h0};
  // pins are only inverted once the bench has released reset
  assign host_data_pins = wiggle ? ~level : level;
  assign clock_source_strap = 1'b1;
endmodule

// ===== tb/reset_strap_config_latch_test.sv
`timescale 1ns/1ns
module reset_strap_config_latch_test;
  import strap_cfg_pkg::*;
  logic        sys_clk = 0;
  logic        sys_rst = 1;
  logic [3:0]  strap_set = 4'h1;
  logic        wiggle = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] rd;
  logic        err;
  wire  [15:0] pins;
  wire  [31:0] prdata;
  wire  [1:0]  lane;
  wire  [5:0]  width;
  wire         clk_strap, pready, pslverr, big, host, sq, rsv, ext, ok;
  int          n_errors = 0;
  int          total_checks = 0;
  board_straps board (.wiggle(wiggle), .strap_set(strap_set),
    .host_data_pins(pins), .clock_source_strap(clk_strap));
  reset_strap_config_latch dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .host_data_pins(pins), .clock_source_strap(clk_strap), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .big_endian(big), .narrow_lane_select(lane), .boot_from_host_port(host),
    .rom_width(width), .clock_source_square_wave(sq),
    .clock_source_reserved(rsv), .memory_clock_external(ext),
    .config_valid(ok));
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_for(bit on_ready);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((on_ready ? pready : ok) !== 1'b1 && n < 20);
    if ((on_ready ? pready : ok) !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d, logic [3:0] s);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1;
    wait_for(1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic do_reset(logic [3:0] s);
    wiggle <= 0;
    strap_set <= s;
    sys_rst <= 1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 0;
    wait_for(0);
    @(posedge sys_clk);
  endtask
  // every lane, order and boot code combination
  task automatic test_straps();
    for (int i = 0; i < 16; i++) begin
      do_reset(i[3:0]);
      check("big_endian", big, !i[2]);
      check("lane", lane, (i[3] && !i[2]) ? LANE_TOP : LANE_LOW);
      check("host_boot", host, i[1:0] == 0);
      check("rom_width", width, i[1:0] == 1 ? WIDTH_8 : i[1:0] == 2 ?
            WIDTH_16 : i[1:0] == 3 ? WIDTH_32 : 6'h00);
      check("clock_src", {sq, rsv}, 2'h2);
    end
    $display("straps test done");
  endtask
  // pin activity after release must not disturb the latch
  task automatic test_hold();
    do_reset(4'hb);
    wiggle <= 1;
    repeat (5) @(posedge sys_clk);
    check("held", {big, lane, width}, {1'b1, LANE_TOP, WIDTH_32});
    $display("hold test done");
  endtask
  // config register access and refusals
  task automatic test_regs();
    do_reset(4'h1);
    apb(0, DEVICE_CONFIGURATION_ADDR, 0, 4'hf);
    check("cfg_reset", rd, DEVICE_CONFIGURATION_RST);
    check("cfg_ok", err, 0);
    apb(0, STRAP_STATUS_ADDR, 0, 4'hf);
    check("status", rd, 32'h00000811);
    apb(1, DEVICE_CONFIGURATION_ADDR, 32'hffffffff, 4'hf);
    repeat (2) @(posedge sys_clk);
    check("ext_clk", ext, 1);
    apb(0, DEVICE_CONFIGURATION_ADDR, 0, 4'hf);
    check("cfg_read", rd, 32'h00000010);
    apb(1, DEVICE_CONFIGURATION_ADDR, 0, 4'he);
    repeat (2) @(posedge sys_clk);
    check("strobe_off", ext, 1);
    apb(1, DEVICE_CONFIGURATION_ADDR, 0, 4'hf);
    repeat (2) @(posedge sys_clk);
    check("ext_clr", ext, 0);
    apb(0, 32'h019c0208, 0, 4'hf);
    check("unmapped", err, 1);
    apb(1, STRAP_STATUS_ADDR, 0, 4'hf);
    check("status_wr", err, 1);
    $display("register test done");
  endtask
  // main sequence
  initial begin
    test_straps();
    test_hold();
    test_regs();
    give_verdict();
  end
endmodule
